// [logic/afr_consts.vh]
// constants for the adc frame readout block
`ifndef AFR_CONSTS_VH
`define AFR_CONSTS_VH

// ----------------------------------------------------------------
// frame shape
// ----------------------------------------------------------------
`define AFR_WORD_BITS 24
`define AFR_FRAME_WORDS 6
`define AFR_WORD_LAST 3'd5
`define AFR_BIT_LAST 5'd23
`define AFR_CRC_WORD 3'd5
`define AFR_CMD_WORD 3'd0

// ----------------------------------------------------------------
// commands, crc and timing
// ----------------------------------------------------------------
`define AFR_CMD_NULL 24'h000000
`define AFR_PAD_BYTE 8'h00
`define AFR_CRC_INIT 16'hffff
`define AFR_CRC_POLY 16'h1021
`define AFR_OVERSAMPLING_RATIO 512
`define AFR_STATUS_RST 16'h0000

`endif

// [logic/afr_pin_sync.v]
// pin synchroniser and edge finder for the serial link inputs
`default_nettype none

module afr_pin_sync
(
	// clock and reset
	input wire clock,
	input wire rst,
	// raw pins
	input wire sclk_pin,
	input wire cs_n_pin,
	input wire mosi_pin,
	// synchronised view
	output wire sclk_rise,
	output wire sclk_fall,
	output wire cs_fall,
	output wire cs_rise,
	output wire cs_low,
	output wire mosi_s
);

reg [1:0] sclk_meta_r;
reg [1:0] cs_meta_r;
reg [1:0] mosi_meta_r;
reg sclk_d_r;
reg cs_d_r;

// ----------------------------------------------------------------
// two flops per pin, then a third stage on sclk and cs for edge finding
// ----------------------------------------------------------------
always @(posedge clock or posedge rst)
begin
	if (rst)
	begin
		sclk_meta_r <= 2'h0;
		cs_meta_r <= 2'h3;
		mosi_meta_r <= 2'h0;
		sclk_d_r <= 1'b0;
		cs_d_r <= 1'b1;
	end
	else
	begin
		sclk_meta_r <= {sclk_meta_r[0], sclk_pin};
		cs_meta_r <= {cs_meta_r[0], cs_n_pin};
		mosi_meta_r <= {mosi_meta_r[0], mosi_pin};
		sclk_d_r <= sclk_meta_r[1];
		cs_d_r <= cs_meta_r[1];
	end
end

// sclk edges only count while the frame is selected
assign sclk_rise = sclk_meta_r[1] & ~sclk_d_r & ~cs_meta_r[1];
assign sclk_fall = ~sclk_meta_r[1] & sclk_d_r & ~cs_meta_r[1];
assign cs_fall = ~cs_meta_r[1] & cs_d_r;
assign cs_rise = cs_meta_r[1] & ~cs_d_r;
assign cs_low = ~cs_meta_r[1];
assign mosi_s = mosi_meta_r[1];

endmodule

`default_nettype wire

// [logic/afr_top.v]
// adc frame readout: sample pacing, ready strobe and serial frame slave
`include "afr_consts.vh"
`default_nettype none

// How it works
// RQ1 - new sample set every oversampling ratio cycles
// RQ2 - ready line falls when set is ready
// RQ3 - host counts ready pulses in detection mode
// RQ4 - host buffers previous set before reading
// RQ5 - host drops chip select before frame
// RQ6 - frame is six words of three bytes
// RQ7 - host sends all-zero null command first
// RQ8 - response to previous command shifts out first
// RQ9 - null command answered with status contents
// RQ10 - host sends zero dummy bytes after command
// RQ11 - channels zero to three follow, msb first
// RQ12 - host clocks unused channel three fully
// RQ13 - last word holds crc, low byte zero
// RQ14 - host clocks the zero padded crc byte
// RQ15 - host checks crc from bytes sixteen, seventeen
// RQ16 - host raises chip select after frame
// RQ17 - host flags tamper above two events
// RQ18 - channel roles voltage, shunt, transformer current
// RQ19 - chip select held low whole frame
// RQ20 - samples are signed two's complement
module afr_top
#(
	parameter SW = `AFR_WORD_BITS,
	parameter OVERSAMPLING_RATIO = `AFR_OVERSAMPLING_RATIO
)
(
	// clock and reset
	input wire clock,
	input wire rst,
	// serial link from the host
	input wire sclk,
	input wire cs_n,
	input wire mosi,
	output reg miso_o,
	output reg miso_oe,
	output reg sample_ready_n,
	// converter core side
	input wire [SW-1:0] ch0_sample,
	input wire [SW-1:0] ch1_sample,
	input wire [SW-1:0] ch2_sample,
	input wire [SW-1:0] ch3_sample,
	input wire [15:0] status_word,
	input wire current_detect_mode,
	input wire detect_event,
	// last command word taken from the host
	output reg [SW-1:0] last_cmd,
	output reg frame_ok
);

localparam [9:0] RATIO_LAST = OVERSAMPLING_RATIO[9:0] - 10'h001;

wire sclk_rise;
wire sclk_fall;
wire cs_fall;
wire cs_rise;
wire cs_low;
wire mosi_s;

reg [9:0] ratio_cnt_r;
reg [SW-1:0] ch_r [0:3];
reg [SW-1:0] resp_r;
reg [SW-1:0] cmd_sh_r;
reg [15:0] crc_r;
reg [2:0] word_r;
reg [4:0] bit_r;
reg done_r;
reg pend_r;
reg [SW-1:0] word_nxt;
integer i;

// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
function [15:0] crc_step;
	input [15:0] c;
	input b;
	begin
		crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `AFR_CRC_POLY : 16'h0000);
	end
endfunction

afr_pin_sync u_sync
(
	.clock(clock),
	.rst(rst),
	.sclk_pin(sclk),
	.cs_n_pin(cs_n),
	.mosi_pin(mosi),
	.sclk_rise(sclk_rise),
	.sclk_fall(sclk_fall),
	.cs_fall(cs_fall),
	.cs_rise(cs_rise),
	.cs_low(cs_low),
	.mosi_s(mosi_s)
);

// ----------------------------------------------------------------
// sample pacing
// ----------------------------------------------------------------
wire ratio_tick = (ratio_cnt_r == RATIO_LAST); // RQ1
wire new_set = current_detect_mode ? detect_event : ratio_tick;

always @(posedge clock or posedge rst)
begin
	if (rst)
		ratio_cnt_r <= 10'h000;
	else if (ratio_tick)
		ratio_cnt_r <= 10'h000; // RQ1
	else
		ratio_cnt_r <= ratio_cnt_r + 10'h001;
end

// a set is never swapped under a running frame; it waits for the end, and is never taken in detection mode
always @(posedge clock or posedge rst)
begin
	if (rst)
	begin
		for (i = 0; i < 4; i = i + 1)
			ch_r[i] <= {SW{1'b0}};
		pend_r <= 1'b0;
		sample_ready_n <= 1'b1;
	end
	else
	begin
		if ((new_set | pend_r) & ~cs_low & ~current_detect_mode)
		begin
			ch_r[0] <= ch0_sample;
			ch_r[1] <= ch1_sample;
			ch_r[2] <= ch2_sample;
			ch_r[3] <= ch3_sample;
		end
		if (new_set & cs_low)
			pend_r <= 1'b1;
		else if (~cs_low)
			pend_r <= 1'b0;
		if (new_set)
			sample_ready_n <= 1'b0; // RQ2
		else if (cs_fall)
			sample_ready_n <= 1'b1; // RQ2
	end
end

// ----------------------------------------------------------------
// outgoing word select
// ----------------------------------------------------------------
always @*
begin
	case (word_r)
		`AFR_CMD_WORD: word_nxt = resp_r; // RQ8
		3'd1: word_nxt = ch_r[0]; // RQ11
		3'd2: word_nxt = ch_r[1]; // RQ11
		3'd3: word_nxt = ch_r[2]; // RQ11
		3'd4: word_nxt = ch_r[3]; // RQ11
		`AFR_CRC_WORD: word_nxt = {crc_r, `AFR_PAD_BYTE}; // RQ13
		default: word_nxt = {SW{1'b0}};
	endcase
end

// ----------------------------------------------------------------
// serial frame: data out on rising sclk, mosi taken on falling sclk
// ----------------------------------------------------------------
always @(posedge clock or posedge rst)
begin
	if (rst)
	begin
		miso_o <= 1'b0;
		miso_oe <= 1'b0;
		word_r <= 3'h0;
		bit_r <= 5'h00;
		done_r <= 1'b0;
		crc_r <= `AFR_CRC_INIT;
		cmd_sh_r <= {SW{1'b0}};
	end
	else if (cs_fall)
	begin
		miso_o <= 1'b0;
		miso_oe <= 1'b1;
		word_r <= 3'h0;
		bit_r <= 5'h00;
		done_r <= 1'b0;
		crc_r <= `AFR_CRC_INIT;
	end
	else if (cs_rise)
	begin
		miso_oe <= 1'b0;
		miso_o <= 1'b0;
	end
	else
	begin
		// msb first within each word
		if (sclk_rise & ~done_r)
		begin
			miso_o <= word_nxt[`AFR_BIT_LAST - bit_r]; // RQ11
			if (word_r != `AFR_CRC_WORD)
				crc_r <= crc_step(crc_r, word_nxt[`AFR_BIT_LAST - bit_r]);
		end
		if (sclk_fall & ~done_r)
		begin
			if (word_r == `AFR_CMD_WORD)
				cmd_sh_r <= {cmd_sh_r[SW-2:0], mosi_s};
			if (bit_r == `AFR_BIT_LAST)
			begin
				bit_r <= 5'h00;
				if (word_r == `AFR_WORD_LAST)
					done_r <= 1'b1; // RQ6
				else
					word_r <= word_r + 3'h1;
			end
			else
				bit_r <= bit_r + 5'h01;
		end
	end
end

// ----------------------------------------------------------------
// command capture and the response for the next frame
// ----------------------------------------------------------------
// a cut-short frame leaves the pending response untouched
always @(posedge clock or posedge rst)
begin
	if (rst)
	begin
		resp_r <= {`AFR_STATUS_RST, `AFR_PAD_BYTE};
		last_cmd <= {SW{1'b0}};
		frame_ok <= 1'b0;
	end
	else if (cs_rise)
	begin
		frame_ok <= done_r; // RQ6
		if (done_r)
		begin
			last_cmd <= cmd_sh_r;
			if (cmd_sh_r == `AFR_CMD_NULL)
				resp_r <= {status_word, `AFR_PAD_BYTE}; // RQ9
			else
				resp_r <= cmd_sh_r;
		end
	end
end

endmodule

`default_nettype wire

// [test/afr_chk.sv]
// port assertions for the adc frame readout block
`default_nettype none
module afr_chk
#(
	parameter RATIO = 512
)
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// link and ready
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic miso_o,
	input wire logic miso_oe,
	input wire logic sample_ready_n,
	// mode
	input wire logic current_detect_mode,
	input wire logic detect_event
);
	timeunit 1ns;
	timeprecision 1ps;
	int cyc_r;
	// ----------------
	// cycles since reset, saturating so it never wraps
	// ----------------
	always @(posedge clock or posedge rst)
		if (rst)
			cyc_r <= 0;
		else if (cyc_r < 4096)
			cyc_r <= cyc_r + 1;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_ready_early: assert property (cyc_r < RATIO - 4 |-> sample_ready_n)
		else $error("ready before first tick");
	a_ready_tick: assert property (cyc_r == RATIO + 2 |-> !sample_ready_n)
		else $error("no ready at first tick");
	a_oe_on: assert property ($fell(cs_n) |-> ##[2:5] miso_oe)
		else $error("no drive after select");
	a_oe_off: assert property (cs_n [*5] |=> !miso_oe)
		else $error("drive while deselected");
	a_oe_hold: assert property (miso_oe && !cs_n |=> miso_oe)
		else $error("drive dropped in frame");
	a_ready_clr: assert property ($fell(cs_n) |-> ##[2:5] sample_ready_n)
		else $error("ready not cleared");
	a_ready_keep: assert property ((cs_n [*4] ##0 !sample_ready_n)
		|=> !sample_ready_n)
		else $error("ready rose unread");
	a_detect_ready: assert property (current_detect_mode && detect_event
		|=> !sample_ready_n)
		else $error("detect event lost");
	a_miso_hold: assert property (((!sclk) [*6] ##0 miso_oe
		&& $past(miso_oe)) |-> $stable(miso_o))
		else $error("data moved without clock");
endmodule
bind afr_top afr_chk #(.RATIO(OVERSAMPLING_RATIO)) i_chk (.clock, .rst,
	.sclk, .cs_n, .miso_o, .miso_oe, .sample_ready_n, .current_detect_mode,
	.detect_event);
`default_nettype wire

// [test/afr_host.sv]
// host model: spi mode 1 master clocking frames from the block
`default_nettype none
module afr_host
(
	// bench clock
	input wire logic clock,
	// serial link
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic lb = 1'b0;
	initial {sclk, cs_n, mosi} = 3'h2;
	// ----------------
	// one frame, cut short when bits < 144
	// ----------------
	task automatic xfer(input logic [23:0] cmd, input int bits,
		output logic [143:0] rx);
		rx = '0;
		@(posedge clock) cs_n <= 1'b0;
		repeat (8) @(posedge clock);
		for (int i = 0; i < bits; i++)
		begin
			sclk <= 1'b1;
			mosi <= i < 24 ? cmd[23 - i] : 1'b0;
			repeat (8) @(posedge clock);
			sclk <= 1'b0;
			// a released line shows no stale bit
			lb = miso_oe ? miso_o : ~lb;
			rx = {rx[142:0], lb};
			repeat (8) @(posedge clock);
		end
		cs_n <= 1'b1;
		repeat (8) @(posedge clock);
	endtask
endmodule
`default_nettype wire

// [test/adc_frame_readout_test.sv]
// self-checking bench for the adc frame readout block
`default_nettype none
`define AFR_CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
$display("wrong value at %0t: %h", $time, g); end end
module adc_frame_readout_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic sclk, cs_n, mosi, miso_o, miso_oe, sample_ready_n, frame_ok;
	logic current_detect_mode = 1'b0;
	logic detect_event = 1'b0;
	logic [23:0] ch [4];
	logic [23:0] cmds [4];
	logic [23:0] last_cmd, resp;
	logic [15:0] status_word;
	logic [31:0] seed = 32'h0001835f;
	logic [143:0] rx;
	logic signed [23:0] held [$];
	int fails = 0;
	int checks = 0;
	int cyc = 0;
	int tamper = 0;
	afr_top #(.OVERSAMPLING_RATIO(512)) i_dut (.clock, .rst, .sclk, .cs_n,
		.mosi, .miso_o, .miso_oe, .sample_ready_n, .ch0_sample(ch[0]),
		.ch1_sample(ch[1]), .ch2_sample(ch[2]), .ch3_sample(ch[3]),
		.status_word, .current_detect_mode, .detect_event, .last_cmd,
		.frame_ok);
	afr_host i_host (.clock, .sclk, .cs_n, .mosi, .miso_o, .miso_oe);
	initial forever #5 clock = ~clock;
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			fails++;
			wrap_up();
		end
	end
	// ----------------
	// reference helpers
	// ----------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [15:0] crc(input logic [119:0] d);
		logic [15:0] c;
		c = 16'hffff;
		for (int i = 119; i >= 0; i--)
			c = (c << 1) ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
		return c;
	endfunction
	task automatic wrap_up;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// inputs change only mid-frame, so the set read next is known
	task automatic frame(input logic [23:0] cmd);
		logic [119:0] b;
		b = {resp, ch[0], ch[1], ch[2], ch[3]};
		for (int n = 0; n < 600 && sample_ready_n !== 1'b0; n++)
			@(negedge clock);
		`AFR_CHK(sample_ready_n, 1'b0)
		held.push_back($signed(rx[119:96]));
		fork
			i_host.xfer(cmd, 144, rx);
			begin
				repeat (40) @(posedge clock);
				for (int k = 0; k < 4; k++)
				begin
					seed = xs(seed);
					ch[k] <= seed[23:0];
				end
			end
		join
		`AFR_CHK(rx, {b, crc(b), 8'h00})
		`AFR_CHK(rx[23:8], crc(rx[143:24]))
		`AFR_CHK($signed(rx[119:96]) < 0, b[95])
		`AFR_CHK({frame_ok, last_cmd}, {1'b1, cmd})
		resp = cmd === 24'h0 ? {status_word, 8'h00} : cmd;
	endtask
	initial
	begin
		status_word = seed[15:0];
		foreach (ch[k])
			ch[k] = 24'h000100 * k;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		`AFR_CHK({miso_o, miso_oe, sample_ready_n, frame_ok, last_cmd},
			28'h2000000)
		resp = 24'h000000;
		seed = xs(seed);
		cmds = '{24'h000000, seed[23:0], 24'h000000, 24'h000000};
		foreach (cmds[i])
			frame(cmds[i]);
		current_detect_mode <= 1'b1;
		tamper = 0;
		for (int t = 0; t < 3; t++)
		begin
			i_host.xfer(24'h000000, 0, rx);
			repeat (600) @(posedge clock);
			`AFR_CHK(sample_ready_n, 1'b1)
			detect_event <= 1'b1;
			@(posedge clock) detect_event <= 1'b0;
			repeat (2) @(posedge clock);
			if (sample_ready_n === 1'b0)
				tamper++;
		end
		`AFR_CHK(tamper > 2, 1'b1)
		`AFR_CHK(held.size(), 4)
		`AFR_CHK({frame_ok, last_cmd}, {1'b0, cmds[3]})
		wrap_up();
	end
endmodule
`default_nettype wire
